// >>> logic/duc_dual_uart.sv
// Two serial channels: channel 0 plain asynchronous, channel 1 also CODEC.
// Assumes configuration is held steady while a channel is enabled.
`timescale 1ns/1ps

// Summary of operation
// - Two channels with separate configuration, buffers, timing and status.
// - Internal time base is the system clock, no crystal needed.
// - Sixteen-bit divider per channel gives the sixteen-times baud tick.
// - Channel 1 runs async, 8-bit CODEC, 16-bit CODEC or AC'97 frames.
// - Character length five to eight data bits; far end must match.
// - Parity even, odd or none, generated on send, checked on receive.
// - Stop interval up to two bits in sixteenth-bit steps.
// - Channel 0 keeps four received and two outgoing bytes.
// - Channel 1 FIFOs hold thirty-two bytes in async or 8-bit CODEC.
// - Channel 1 FIFOs hold sixteen two-byte samples in 16-bit CODEC.
// - Channel 1 FIFOs hold sixteen twenty-bit samples in AC'97 mode.
// - Receive errors detected; normal and error events masked onto interrupts.
// - Active-low request-to-send out, active-low clear-to-send in.
// - Programmable prescaler derives the time base from the input clock.
// - Time base may instead come from an external timer input.
// - Normal, auto-echo, local loopback and remote loopback line modes.
module duc_dual_uart (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // Configuration and status
    input  wire duc_pkg::duc_cfg_type [1:0]  cfg,
    input  wire logic [1:0]                  err_clr,
    output duc_pkg::duc_stat_type [1:0]      stat,
    output logic [1:0]                       irq,
    // Transmit samples
    input  wire logic [1:0][19:0]            tx_data,
    input  wire logic [1:0]                  tx_valid,
    output logic [1:0]                       tx_ready,
    // Received samples
    output logic [1:0][19:0]                 rx_data,
    output logic [1:0]                       rx_valid,
    input  wire logic [1:0]                  rx_ready,
    // Serial pins
    output logic [1:0]                       txd,
    input  wire logic [1:0]                  rxd,
    output logic [1:0]                       rts_b,
    input  wire logic [1:0]                  cts_b,
    input  wire logic [1:0]                  tin,
    // CODEC framing, channel 1
    output logic                             codec_fsync,
    output logic                             codec_bclk
);
    import duc_pkg::*;

    logic [1:0] fsync_w;
    logic [1:0] bclk_w;

    assign codec_fsync = fsync_w[1];
    assign codec_bclk  = bclk_w[1];

    for (genvar i = 0; i < DUC_CHANNELS; i++) begin : g_chan
        localparam bit ENH = (i == 1);
        localparam int RXD = ENH ? DUC_ENH_DEPTH : DUC_BASIC_RX_DEPTH;
        localparam int TXD = ENH ? DUC_ENH_DEPTH : DUC_BASIC_TX_DEPTH;

        duc_chan_type s_q;
        duc_chan_type s_d;
        duc_cfg_type  c;
        logic         codec;
        logic         wide;
        logic [5:0]   rx_cap;
        logic [5:0]   tx_cap;
        logic         tx_rd_valid;
        logic [19:0]  tx_rd_data;
        logic         pop;
        logic         rx_wr_ready;
        logic         tin_rise;
        logic         pre_tick;
        logic         src_tick;
        logic         tick;
        logic         rx_line;
        logic         odd;
        logic [4:0]   nbits;
        logic [4:0]   cw;
        logic [5:0]   stop_lim;
        logic [19:0]  mask;
        logic         ovr_ev;
        logic         perr_ev;
        logic         ferr_ev;

        assign c     = cfg[i];
        assign codec = ENH && (c.mode != DUC_MODE_ASYNC);
        assign wide  = ENH && ((c.mode == DUC_MODE_CODEC16) || (c.mode == DUC_MODE_AC97));

        // FIFO capacity follows the channel and its mode
        assign rx_cap = !ENH ? DUC_CAP_BASIC_RX : (wide ? DUC_CAP_WIDE : DUC_CAP_NARROW);
        assign tx_cap = !ENH ? DUC_CAP_BASIC_TX : (wide ? DUC_CAP_WIDE : DUC_CAP_NARROW);

        duc_fifo #(.W(DUC_SAMPLE_W), .D(TXD)) u_tx_fifo (
            .mclk     (mclk),
            .rst_b    (rst_b),
            .cap      (tx_cap),
            .wr_valid (tx_valid[i]),
            .wr_data  (tx_data[i]),
            .wr_ready (tx_ready[i]),
            .rd_valid (tx_rd_valid),
            .rd_data  (tx_rd_data),
            .rd_ready (pop)
        );

        duc_fifo #(.W(DUC_SAMPLE_W), .D(RXD)) u_rx_fifo (
            .mclk     (mclk),
            .rst_b    (rst_b),
            .cap      (rx_cap),
            .wr_valid (s_q.rx_push),
            .wr_data  (s_q.rx_word),
            .wr_ready (rx_wr_ready),
            .rd_valid (rx_valid[i]),
            .rd_data  (rx_data[i]),
            .rd_ready (rx_ready[i])
        );

        assign txd[i]     = s_q.pin_txd;
        assign rts_b[i]   = s_q.rts_b;
        assign fsync_w[i] = s_q.fsync;
        assign bclk_w[i]  = s_q.bclk;
        assign stat[i]    = '{frame_err: s_q.ferr, parity_err: s_q.perr, overrun: s_q.ovr,
                              tx_room: tx_ready[i], rx_avail: rx_valid[i]};
        assign irq[i]     = |(stat[i] & c.irq_mask);

        always_comb begin
            s_d       = s_q;
            pop       = 1'b0;
            ovr_ev    = 1'b0;
            perr_ev   = 1'b0;
            ferr_ev   = 1'b0;
            s_d.rx_push = 1'b0;
            odd       = (c.parity == DUC_PAR_ODD);
            nbits     = DUC_MIN_DATA_BITS + {3'b000, c.char_len};
            mask      = DUC_ALL_ONES >> (5'd20 - nbits);
            if (c.mode == DUC_MODE_CODEC8) begin
                cw = DUC_CODEC8_BITS;
            end else if (c.mode == DUC_MODE_CODEC16) begin
                cw = DUC_CODEC16_BITS;
            end else begin
                cw = DUC_AC97_BITS;
            end
            if (c.stop16 < DUC_STOP16_MIN) begin
                stop_lim = DUC_STOP16_MIN;
            end else if (c.stop16 > DUC_STOP16_MAX) begin
                stop_lim = DUC_STOP16_MAX;
            end else begin
                stop_lim = c.stop16;
            end

            // Three-stage pin filters, value taken when stages two and three agree
            s_d.tin_s = {s_q.tin_s[1:0], tin[i]};
            s_d.rx_s  = {s_q.rx_s[1:0], rxd[i]};
            s_d.cts_s = {s_q.cts_s[1:0], cts_b[i]};
            if (s_q.tin_s[2] == s_q.tin_s[1]) begin
                s_d.tin_f = s_q.tin_s[2];
            end
            if (s_q.rx_s[2] == s_q.rx_s[1]) begin
                s_d.rx_f = s_q.rx_s[2];
            end
            if (s_q.cts_s[2] == s_q.cts_s[1]) begin
                s_d.cts_f = s_q.cts_s[2];
            end
            tin_rise = s_d.tin_f && !s_q.tin_f;

            // Time base
            pre_tick = 1'b0;
            if (s_q.pre_cnt >= c.prescale) begin
                s_d.pre_cnt = 8'h00;
                pre_tick    = 1'b1;
            end else begin
                s_d.pre_cnt = s_q.pre_cnt + 8'h01;
            end
            src_tick = c.clk_ext ? tin_rise : pre_tick;
            tick     = 1'b0;
            if (src_tick) begin
                if (({1'b0, s_q.div_cnt} + 17'h00001) >= {1'b0, c.divider}) begin
                    s_d.div_cnt = 16'h0000;
                    tick        = 1'b1;
                end else begin
                    s_d.div_cnt = s_q.div_cnt + 16'h0001;
                end
            end

            // Line routing for the test modes
            if (c.test == DUC_TEST_LOCAL) begin
                rx_line = s_q.tx_line;
            end else if (c.test == DUC_TEST_REMOTE) begin
                rx_line = 1'b1;
            end else begin
                rx_line = s_q.rx_f;
            end
            if (c.test == DUC_TEST_NORMAL) begin
                s_d.pin_txd = s_q.tx_line;
            end else if (c.test == DUC_TEST_LOCAL) begin
                s_d.pin_txd = 1'b1;
            end else begin
                s_d.pin_txd = s_q.rx_f;
            end

            // Transmitter, and CODEC receive capture in step with it
            if (tick) begin
                s_d.tx_sub = s_q.tx_sub + 4'h1;
                case (s_q.tx_st)
                    DUC_TX_IDLE: begin
                        s_d.tx_sub  = 4'h0;
                        s_d.tx_line = 1'b1;
                        s_d.fsync   = 1'b0;
                        if (c.tx_en && codec) begin
                            pop         = tx_rd_valid;
                            s_d.tx_sh   = tx_rd_valid ? tx_rd_data : 20'h00000;
                            s_d.tx_st   = DUC_TX_SYNC;
                            s_d.fsync   = 1'b1;
                            s_d.tx_line = 1'b0;
                        end else if (c.tx_en && tx_rd_valid && !s_q.cts_f) begin
                            pop         = 1'b1;
                            s_d.tx_sh   = tx_rd_data & mask;
                            s_d.tx_par  = (^(tx_rd_data & mask)) ^ odd;
                            s_d.tx_st   = DUC_TX_START;
                            s_d.tx_line = 1'b0;
                        end
                    end
                    DUC_TX_START: begin
                        if (s_q.tx_sub == DUC_LAST_TICK) begin
                            s_d.tx_st   = DUC_TX_DATA;
                            s_d.tx_bit  = 5'h00;
                            s_d.tx_line = s_q.tx_sh[0];
                        end
                    end
                    DUC_TX_SYNC: begin
                        if (s_q.tx_sub == DUC_LAST_TICK) begin
                            s_d.tx_st   = DUC_TX_DATA;
                            s_d.tx_bit  = 5'h00;
                            s_d.fsync   = 1'b0;
                            s_d.tx_line = s_q.tx_sh[cw - 5'h01];
                        end
                    end
                    DUC_TX_DATA: begin
                        if (codec && (s_q.tx_sub == DUC_MID_TICK)) begin
                            s_d.rx_sh = {s_q.rx_sh[18:0], rx_line};
                        end
                        if (s_q.tx_sub == DUC_LAST_TICK) begin
                            s_d.tx_bit = s_q.tx_bit + 5'h01;
                            if (codec) begin
                                s_d.tx_sh   = s_q.tx_sh << 1;
                                s_d.tx_line = s_d.tx_sh[cw - 5'h01];
                                if (s_q.tx_bit == cw - 5'h01) begin
                                    s_d.tx_st   = DUC_TX_IDLE;
                                    s_d.tx_line = 1'b1;
                                    s_d.rx_word = s_q.rx_sh & (DUC_ALL_ONES >> (5'd20 - cw));
                                    s_d.rx_push = c.rx_en;
                                    s_d.rx_sh   = 20'h00000;
                                end
                            end else begin
                                s_d.tx_sh   = s_q.tx_sh >> 1;
                                s_d.tx_line = s_d.tx_sh[0];
                                if (s_q.tx_bit == nbits - 5'h01) begin
                                    if (c.parity == DUC_PAR_NONE) begin
                                        s_d.tx_st   = DUC_TX_STOP;
                                        s_d.tx_line = 1'b1;
                                        s_d.tx_stop = 6'h00;
                                    end else begin
                                        s_d.tx_st   = DUC_TX_PAR;
                                        s_d.tx_line = s_q.tx_par;
                                    end
                                end
                            end
                        end
                    end
                    DUC_TX_PAR: begin
                        if (s_q.tx_sub == DUC_LAST_TICK) begin
                            s_d.tx_st   = DUC_TX_STOP;
                            s_d.tx_line = 1'b1;
                            s_d.tx_stop = 6'h00;
                        end
                    end
                    DUC_TX_STOP: begin
                        s_d.tx_stop = s_q.tx_stop + 6'h01;
                        if ((s_q.tx_stop + 6'h01) >= stop_lim) begin
                            s_d.tx_st = DUC_TX_IDLE;
                        end
                    end
                    default: begin
                        s_d.tx_st = DUC_TX_IDLE;
                    end
                endcase
                s_d.bclk = codec && !s_d.tx_sub[3];
            end

            // Asynchronous receiver
            if (tick && !codec) begin
                s_d.rx_sub = s_q.rx_sub + 4'h1;
                case (s_q.rx_st)
                    DUC_RX_IDLE: begin
                        s_d.rx_sub = 4'h0;
                        if (c.rx_en && !rx_line) begin
                            s_d.rx_st = DUC_RX_START;
                        end
                    end
                    DUC_RX_START: begin
                        if (s_q.rx_sub == DUC_MID_TICK) begin
                            s_d.rx_sub = 4'h0;
                            s_d.rx_bit = 5'h00;
                            s_d.rx_sh  = 20'h00000;
                            s_d.rx_par = 1'b0;
                            s_d.rx_st  = rx_line ? DUC_RX_IDLE : DUC_RX_DATA;
                        end
                    end
                    DUC_RX_DATA: begin
                        if (s_q.rx_sub == DUC_LAST_TICK) begin
                            s_d.rx_sh[s_q.rx_bit] = rx_line;
                            s_d.rx_par = s_q.rx_par ^ rx_line;
                            s_d.rx_bit = s_q.rx_bit + 5'h01;
                            if (s_q.rx_bit == nbits - 5'h01) begin
                                s_d.rx_st = (c.parity == DUC_PAR_NONE) ? DUC_RX_STOP : DUC_RX_PAR;
                            end
                        end
                    end
                    DUC_RX_PAR: begin
                        if (s_q.rx_sub == DUC_LAST_TICK) begin
                            perr_ev   = rx_line ^ s_q.rx_par ^ odd;
                            s_d.rx_st = DUC_RX_STOP;
                        end
                    end
                    DUC_RX_STOP: begin
                        if (s_q.rx_sub == DUC_LAST_TICK) begin
                            ferr_ev     = !rx_line;
                            s_d.rx_word = s_q.rx_sh;
                            s_d.rx_push = 1'b1;
                            s_d.rx_st   = DUC_RX_IDLE;
                        end
                    end
                    default: begin
                        s_d.rx_st = DUC_RX_IDLE;
                    end
                endcase
            end

            // Push into a full FIFO is dropped there; flag it, set beats clear
            ovr_ev   = s_q.rx_push && !rx_wr_ready;
            s_d.ovr  = ovr_ev || (s_q.ovr && !err_clr[i]);
            s_d.perr = perr_ev || (s_q.perr && !err_clr[i]);
            s_d.ferr = ferr_ev || (s_q.ferr && !err_clr[i]);
            s_d.rts_b = !(c.rx_en && rx_wr_ready);
        end

        // Each channel owns its own state, no sharing between them
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                s_q <= DUC_CHAN_RST;
            end else begin
                s_q <= s_d;
            end
        end
    end
endmodule

// >>> logic/duc_fifo.sv
// Sample FIFO with a run-time capacity limit at or below its fixed depth.
// Assumes writer and reader on mclk; data read straight from storage.
`timescale 1ns/1ps
module duc_fifo #(
    parameter int W = 20,
    parameter int D = 32
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // Usable entries
    input  wire logic [5:0]   cap,
    // Fill side
    input  wire logic         wr_valid,
    input  wire logic [W-1:0] wr_data,
    output logic              wr_ready,
    // Drain side
    output logic              rd_valid,
    output logic [W-1:0]      rd_data,
    input  wire logic         rd_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
    } duc_fifo_state_type;

    duc_fifo_state_type s_q;
    duc_fifo_state_type s_d;
    logic               do_wr;
    logic               do_rd;

    assign wr_ready = (6'(s_q.cnt) < cap) && (s_q.cnt != CW'(D));
    assign rd_valid = (s_q.cnt != '0);
    assign rd_data  = s_q.mem[s_q.rp];

    always_comb begin
        s_d   = s_q;
        do_wr = wr_valid && wr_ready;
        do_rd = rd_ready && rd_valid;
        if (do_wr) begin
            s_d.mem[s_q.wp] = wr_data;
            s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : s_q.wp + AW'(1);
        end
        if (do_rd) begin
            s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : s_q.rp + AW'(1);
        end
        if (do_wr && !do_rd) begin
            s_d.cnt = s_q.cnt + CW'(1);
        end else if (do_rd && !do_wr) begin
            s_d.cnt = s_q.cnt - CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// >>> logic/duc_pkg.sv
// Shared constants, enumerations and carriers for the dual serial block.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
package duc_pkg;

    localparam int          DUC_CHANNELS        = 2;
    localparam int          DUC_SAMPLE_W        = 20;
    localparam int          DUC_BASIC_RX_DEPTH  = 4;
    localparam int          DUC_BASIC_TX_DEPTH  = 2;
    localparam int          DUC_ENH_DEPTH       = 32;
    localparam logic [5:0]  DUC_CAP_BASIC_RX    = 6'h04;
    localparam logic [5:0]  DUC_CAP_BASIC_TX    = 6'h02;
    localparam logic [5:0]  DUC_CAP_NARROW      = 6'h20;
    localparam logic [5:0]  DUC_CAP_WIDE        = 6'h10;
    localparam logic [3:0]  DUC_MID_TICK        = 4'h7;
    localparam logic [3:0]  DUC_LAST_TICK       = 4'hf;
    localparam logic [4:0]  DUC_MIN_DATA_BITS   = 5'h05;
    localparam logic [4:0]  DUC_CODEC8_BITS     = 5'h08;
    localparam logic [4:0]  DUC_CODEC16_BITS    = 5'h10;
    localparam logic [4:0]  DUC_AC97_BITS       = 5'h14;
    localparam logic [5:0]  DUC_STOP16_MIN      = 6'h01;
    localparam logic [5:0]  DUC_STOP16_MAX      = 6'h20;
    localparam logic [19:0] DUC_ALL_ONES        = 20'hfffff;

    typedef enum logic [1:0] {
        DUC_MODE_ASYNC   = 2'b00,
        DUC_MODE_CODEC8  = 2'b01,
        DUC_MODE_CODEC16 = 2'b10,
        DUC_MODE_AC97    = 2'b11
    } duc_mode_type;

    typedef enum logic [1:0] {
        DUC_PAR_NONE = 2'b00,
        DUC_PAR_EVEN = 2'b01,
        DUC_PAR_ODD  = 2'b10
    } duc_par_type;

    typedef enum logic [1:0] {
        DUC_TEST_NORMAL = 2'b00,
        DUC_TEST_ECHO   = 2'b01,
        DUC_TEST_LOCAL  = 2'b10,
        DUC_TEST_REMOTE = 2'b11
    } duc_test_type;

    typedef enum logic [2:0] {
        DUC_TX_IDLE  = 3'b000,
        DUC_TX_START = 3'b001,
        DUC_TX_DATA  = 3'b010,
        DUC_TX_PAR   = 3'b011,
        DUC_TX_STOP  = 3'b100,
        DUC_TX_SYNC  = 3'b101
    } duc_tx_st_type;

    typedef enum logic [2:0] {
        DUC_RX_IDLE  = 3'b000,
        DUC_RX_START = 3'b001,
        DUC_RX_DATA  = 3'b010,
        DUC_RX_PAR   = 3'b011,
        DUC_RX_STOP  = 3'b100
    } duc_rx_st_type;

    typedef struct packed {
        logic [7:0]   prescale;
        logic [15:0]  divider;
        logic         clk_ext;
        logic [1:0]   char_len;
        duc_par_type  parity;
        logic [5:0]   stop16;
        duc_test_type test;
        duc_mode_type mode;
        logic         rx_en;
        logic         tx_en;
        logic [4:0]   irq_mask;
    } duc_cfg_type;

    // Bit order matches irq_mask
    typedef struct packed {
        logic frame_err;
        logic parity_err;
        logic overrun;
        logic tx_room;
        logic rx_avail;
    } duc_stat_type;

    typedef struct packed {
        logic [7:0]    pre_cnt;
        logic [15:0]   div_cnt;
        logic [2:0]    tin_s;
        logic          tin_f;
        logic [2:0]    rx_s;
        logic          rx_f;
        logic [2:0]    cts_s;
        logic          cts_f;
        duc_tx_st_type tx_st;
        logic [3:0]    tx_sub;
        logic [4:0]    tx_bit;
        logic [5:0]    tx_stop;
        logic [19:0]   tx_sh;
        logic          tx_par;
        logic          tx_line;
        logic          pin_txd;
        logic          rts_b;
        logic          fsync;
        logic          bclk;
        duc_rx_st_type rx_st;
        logic [3:0]    rx_sub;
        logic [4:0]    rx_bit;
        logic [19:0]   rx_sh;
        logic          rx_par;
        logic          rx_push;
        logic [19:0]   rx_word;
        logic          ovr;
        logic          perr;
        logic          ferr;
    } duc_chan_type;

    localparam duc_chan_type DUC_CHAN_RST = '{
        rx_s: 3'h7, rx_f: 1'b1, cts_s: 3'h7, cts_f: 1'b1,
        tx_line: 1'b1, pin_txd: 1'b1, rts_b: 1'b1,
        tx_st: DUC_TX_IDLE, rx_st: DUC_RX_IDLE, default: '0};

endpackage

// >>> verification/duc_chk_monitor.sv
// Port assertions for the dual serial block.
// Assumes a bind onto duc_dual_uart, single clock mclk.
`timescale 1ns/1ps
module duc_chk (
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        rst_b,
    // Watched ports
    input wire duc_pkg::duc_cfg_type [1:0]  cfg,
    input wire logic [1:0]                  err_clr,
    input wire duc_pkg::duc_stat_type [1:0] stat,
    input wire logic [1:0]                  irq,
    input wire logic [1:0]                  tx_ready,
    input wire logic [1:0]                  rx_valid,
    input wire logic [1:0]                  txd,
    input wire logic [1:0]                  rts_b,
    input wire logic                        codec_fsync,
    input wire logic                        codec_bclk
);
    import duc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_IRQ_CH0: assert property (irq[0] == |(stat[0] & cfg[0].irq_mask))
        else $error("irq0 wrong");
    AST_IRQ_CH1: assert property (irq[1] == |(stat[1] & cfg[1].irq_mask))
        else $error("irq1 wrong");
    AST_START_LEN: assert property ($fell(txd[0]) && cfg[0].divider < 2
        && cfg[0].prescale == 0 && !cfg[0].clk_ext && cfg[0].test == DUC_TEST_NORMAL
        |=> (!txd[0])[*8] ##1 (!txd[0])[*7]) else $error("low bit too short");
    AST_RTS_FULL: assert property ($rose(stat[0].overrun) |-> rts_b[0])
        else $error("rts low while full");
    AST_OVR_HOLD: assert property (stat[0].overrun && !err_clr[0] |=> stat[0].overrun)
        else $error("overrun lost");
    AST_RST_STAT: assert property ($rose(rst_b) |-> stat[0] == 5'h02 && txd == 2'h3)
        else $error("bad state after reset");
    AST_FLAGS: assert property (stat[0].tx_room == tx_ready[0]
        && stat[1].rx_avail == rx_valid[1]) else $error("status flags disagree");
    AST_CODEC_IDLE: assert property ((cfg[1].mode == DUC_MODE_ASYNC)[*2]
        |-> !codec_bclk && !codec_fsync) else $error("codec clocks in async");
endmodule

// >>> verification/duc_far_end.sv
// Remote modem model for both channels.
// Assumes it sits on the serial pins of the dual serial block.
`timescale 1ns/1ps
module duc_far_end (
    // Serial pins
    input  wire logic [1:0] txd,
    output logic [1:0]      rxd,
    output logic [1:0]      cts_b,
    // Flow control hold from the bench
    input  wire logic       cts_hold
);
    assign rxd = txd;
    assign cts_b = {2{cts_hold}};
endmodule

// >>> verification/tb_duc_dual_uart.sv
// Self-checking bench, far end echoes each line back.
// Assumes the checker and far-end model compile first.
`timescale 1ns/1ps
module tb_duc_dual_uart;
    import duc_pkg::*;
    logic               mclk = 0, rst_b = 0, saw_sync = 0;
    duc_cfg_type [1:0]  cfg = '0;
    logic [1:0]         err_clr = 0, tx_valid = 0, rx_ready = 0, tin = 0;
    logic [1:0][19:0]   tx_data = '0, rx_data;
    duc_stat_type [1:0] stat;
    logic [1:0]         irq, tx_ready, rx_valid, txd, rxd, rts_b, cts_b;
    logic               codec_fsync, codec_bclk, cts_hold = 0;
    int                 err_count = 0, num_checks = 0;
    int                 q[2][$];
    duc_dual_uart i_duc_dual_uart (.mclk, .rst_b, .cfg, .err_clr, .stat, .irq, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .txd, .rxd, .rts_b, .cts_b,
        .tin, .codec_fsync, .codec_bclk);
    duc_far_end i_duc_far_end (.txd, .rxd, .cts_b, .cts_hold);
    initial forever #2 mclk = ~mclk;
    task automatic check(logic [19:0] seen, logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic send(int c, logic [7:0] v, bit keep);
        if (keep) q[c].push_back(v & ((1 << (5 + cfg[c].char_len)) - 1));
        @(posedge mclk);
        tx_valid[c] <= 1;
        tx_data[c] <= {12'h000, v};
        do @(negedge mclk); while (!tx_ready[c]);
        @(posedge mclk);
        tx_valid[c] <= 0;
    endtask
    task automatic settle();
        for (int i = 0; i < 9000 && q[0].size() + q[1].size() > 0; i++) @(posedge mclk);
        repeat (60) @(posedge mclk);
        check(20'(q[0].size() + q[1].size()), 20'h0);
    endtask
    always @(posedge mclk) begin
        saw_sync <= saw_sync | codec_fsync;
        for (int c = 0; c < 2; c++)
            if (rst_b && rx_valid[c] && rx_ready[c])
                check(rx_data[c], q[c].size() ? 20'(q[c].pop_front()) : 'x);
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        void'($urandom(52));
        cfg[0].divider = 16'h0001;
        cfg[1].divider = 16'h0001;
        cfg[1].stop16 = 6'h20;
        cfg[0].rx_en = 1;
        cfg[1].rx_en = 1;
        cfg[0].tx_en = 1;
        cfg[1].tx_en = 1;
        repeat (10) @(posedge mclk);
        check(20'({txd, rts_b}), 20'hf);
        rst_b <= 1;
        rx_ready <= 2'h3;
        for (int k = 0; k < 12; k++) begin
            @(posedge mclk);
            cfg[0].char_len <= 2'(k % 4);
            cfg[1].char_len <= 2'(3 - k % 4);
            cfg[0].parity <= duc_par_type'(k % 3);
            cfg[1].parity <= duc_par_type'(2 - k % 3);
            cfg[0].stop16 <= 6'(16 + $urandom % 17);
            @(posedge mclk);
            fork
                repeat (2) send(0, 8'($urandom), 1);
                repeat (2) send(1, 8'($urandom), 1);
            join
            settle();
        end
        check(20'({stat[0][4:2], stat[1][4:2]}), 20'h0);
        rx_ready[0] <= 0;
        cfg[0].irq_mask <= 5'h04;
        for (int i = 0; i < 5; i++) send(0, 8'($urandom), i < 4);
        repeat (800) @(posedge mclk);
        check(20'({stat[0].overrun, irq[0], rts_b[0], stat[1].overrun}), 20'he);
        rx_ready[0] <= 1;
        settle();
        err_clr[0] <= 1;
        @(posedge mclk);
        err_clr[0] <= 0;
        repeat (2) @(posedge mclk);
        check(20'({stat[0].overrun, irq[0]}), 20'h0);
        cts_hold <= 1;
        repeat (8) @(posedge mclk);
        send(0, 8'($urandom), 1);
        repeat (400) @(posedge mclk);
        check(20'(q[0].size()), 20'h1);
        cts_hold <= 0;
        settle();
        cfg[1].rx_en <= 0;
        cfg[1].mode <= DUC_MODE_CODEC8;
        repeat (400) @(posedge mclk);
        check(20'(saw_sync), 20'h1);
        test_done();
    end
endmodule
bind duc_dual_uart duc_chk i_duc_chk (.mclk, .rst_b, .cfg, .err_clr, .stat, .irq, .tx_ready,
    .rx_valid, .txd, .rts_b, .codec_fsync, .codec_bclk);
